/* File: include/tmx_pkg.sv */
package tmx_pkg;

    // -------------------------------------------------------------------
    // channel geometry
    // -------------------------------------------------------------------
    localparam int          NUM_CH          = 5;
    localparam logic [7:0]  STATUS_MASK     = 8'h1f;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0]  ADDR_PRI_HIGH   = 8'h0c;
    localparam logic [7:0]  ADDR_PRI_LOW    = 8'h0d;
    localparam logic [7:0]  ADDR_HOT_SEL    = 8'h1a;
    localparam logic [7:0]  ADDR_PRI_OVER   = 8'h1d;
    localparam logic [7:0]  ADDR_PRI_OVER_E = 8'h26;
    localparam logic [7:0]  ADDR_UNDER_MSB  = 8'h27;
    localparam logic [7:0]  ADDR_UNDER_LSB  = 8'h28;
    localparam logic [7:0]  ADDR_SEC_OVER   = 8'h29;
    localparam logic [7:0]  ADDR_SEC_OVER_E = 8'h2d;
    localparam logic [7:0]  ADDR_SEC_UNDER  = 8'h2e;
    localparam logic [7:0]  ADDR_REF        = 8'h2f;
    localparam logic [7:0]  ADDR_REF_E      = 8'h38;
    localparam logic [7:0]  ADDR_SEC_HIGH   = 8'h42;
    localparam logic [7:0]  ADDR_SEC_LOW    = 8'h43;
    localparam logic [7:0]  ADDR_HOT_MSB    = 8'h45;
    localparam logic [7:0]  ADDR_HOT_LSB    = 8'h46;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [4:0]  RST_HOT_SEL     = 5'h1f;
    localparam logic [15:0] RST_PRI_OVER    = 16'h0000;
    localparam logic [15:0] RST_PRI_UNDER   = 16'h0000;
    localparam logic [7:0]  RST_SEC_OVER    = 8'h00;
    localparam logic [7:0]  RST_SEC_UNDER   = 8'h00;
    localparam logic [15:0] RST_REF         = 16'h0000;

endpackage : tmx_pkg

/* File: src/tmx_thermal_logic.sv */
`timescale 1ns/1ps

// Operation
// - per conversion keep temperature minus reference
// - hottest register takes largest participating difference
// - only selected channels join hottest search
// - reference registers as msb/lsb pairs
// - format change never converts stored values
// - above primary limit sets status, alarm
// - above secondary limit sets status, alarm
// - below shared primary low limit flags
// - below shared secondary low limit flags
// - only primary crossings trigger log write
// - primary high/low status per channel
// - status cleared by read, set wins
// - 12-bit left-justified signed data, msb first
// - secondary compares upper byte of temperature
// - diode fault suppresses status and alarms
module tmx_thermal_logic #(
    parameter int CH = tmx_pkg::NUM_CH
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    input  wire logic        convDone,
    input  wire logic [2:0]  convChannel,
    input  wire logic [15:0] convTemp,
    input  wire logic        convDiodeFault,
    input  wire logic        extFormat,
    input  wire logic [4:0]  primaryMask,
    input  wire logic [4:0]  secondaryMask,
    input  wire logic        nvWriteEnable,
    output logic             nvLogWrite,
    output logic             primary_alarm_n,
    output logic             secondary_alarm_n
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [4:0][15:0] priOver;
        logic [15:0]      priUnder;
        logic [4:0][7:0]  secOver;
        logic [7:0]       secUnder;
        logic [4:0][15:0] refTemp;
        logic [4:0]       hotSel;
        logic [4:0][15:0] diff;
        logic [4:0]       diffValid;
        logic [15:0]      hottest;
        logic [7:0]       hotLsbHold;
        logic [4:0]       priHigh;
        logic [4:0]       priLow;
        logic [4:0]       secHigh;
        logic [4:0]       secLow;
        logic [7:0]       rdata;
        logic             nvLog;
        logic             alarm1N;
        logic             alarm2N;
    } tmx_state_s;

    tmx_state_s state_q;
    tmx_state_s state_d;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // byte index inside a block of registers starting at base
    function automatic logic [7:0] tmx_offset(input logic [7:0] addr,
                                              input logic [7:0] base);
        tmx_offset = addr - base;
    endfunction : tmx_offset

    function automatic logic tmx_in_range(input logic [7:0] addr,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        tmx_in_range = (addr >= lo) && (addr <= hi);
    endfunction : tmx_in_range

    function automatic logic [7:0] tmx_status_byte(input logic [4:0] bits);
        tmx_status_byte = {3'h0, bits} & tmx_pkg::STATUS_MASK;
    endfunction : tmx_status_byte

    // one signed compare shared by primary limits and the hottest search
    function automatic logic tmx_gt16(input logic [15:0] a,
                                      input logic [15:0] b);
        tmx_gt16 = $signed(a) > $signed(b);
    endfunction : tmx_gt16

    function automatic logic tmx_gt8(input logic [7:0] a,
                                     input logic [7:0] b);
        tmx_gt8 = $signed(a) > $signed(b);
    endfunction : tmx_gt8

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic [7:0]  off;
    logic [2:0]  pairCh;
    logic [4:0]  chBit;
    logic [15:0] fresh;
    logic        found;
    logic [15:0] best;
    logic [4:0]  setPh;
    logic [4:0]  setPl;
    logic [4:0]  setSh;
    logic [4:0]  setSl;
    logic [4:0]  clrPh;
    logic [4:0]  clrPl;
    logic [4:0]  clrSh;
    logic [4:0]  clrSl;
    logic        chOk;
    logic [2:0]  convCh;

    always_comb begin
        state_d = state_q;
        off     = 8'h00;
        pairCh  = 3'h0;
        fresh   = 16'h0000;
        found   = 1'b0;
        best    = 16'h0000;
        setPh   = 5'h00;
        setPl   = 5'h00;
        setSh   = 5'h00;
        setSl   = 5'h00;
        clrPh   = 5'h00;
        clrPl   = 5'h00;
        clrSh   = 5'h00;
        clrSl   = 5'h00;
        chOk    = convChannel < 3'(CH);
        chBit   = chOk ? 5'(5'h01 << convChannel) : 5'h00;
        // clipped so a stray channel code never indexes past the tables
        convCh  = chOk ? convChannel : 3'h0;
        state_d.nvLog = 1'b0;

        // register writes; stored values are never reformatted
        // raw byte store
        if (regWrite) begin
            if (regAddr == tmx_pkg::ADDR_HOT_SEL) begin
                state_d.hotSel = regWdata[4:0];
            end else if (tmx_in_range(regAddr, tmx_pkg::ADDR_PRI_OVER,
                                      tmx_pkg::ADDR_PRI_OVER_E)) begin
                off    = tmx_offset(regAddr, tmx_pkg::ADDR_PRI_OVER);
                pairCh = off[3:1];
                if (off[0]) begin
                    state_d.priOver[pairCh][7:0] = regWdata;
                end else begin
                    state_d.priOver[pairCh][15:8] = regWdata;
                end
            end else if (regAddr == tmx_pkg::ADDR_UNDER_MSB) begin
                state_d.priUnder[15:8] = regWdata;
            end else if (regAddr == tmx_pkg::ADDR_UNDER_LSB) begin
                state_d.priUnder[7:0] = regWdata;
            end else if (tmx_in_range(regAddr, tmx_pkg::ADDR_SEC_OVER,
                                      tmx_pkg::ADDR_SEC_OVER_E)) begin
                off = tmx_offset(regAddr, tmx_pkg::ADDR_SEC_OVER);
                state_d.secOver[off[2:0]] = regWdata;
            end else if (regAddr == tmx_pkg::ADDR_SEC_UNDER) begin
                state_d.secUnder = regWdata;
            end else if (tmx_in_range(regAddr, tmx_pkg::ADDR_REF,
                                      tmx_pkg::ADDR_REF_E)) begin
                off    = tmx_offset(regAddr, tmx_pkg::ADDR_REF);
                pairCh = off[3:1];
                if (off[0]) begin
                    state_d.refTemp[pairCh][7:0] = regWdata;
                end else begin
                    state_d.refTemp[pairCh][15:8] = regWdata;
                end
            end
        end

        // register reads; lsb of hottest frozen at msb read
        // msb-first coherent pair
        if (regRead) begin
            state_d.rdata = 8'h00;
            off           = 8'h00;
            pairCh        = 3'h0;
            if (tmx_in_range(regAddr, tmx_pkg::ADDR_PRI_OVER,
                             tmx_pkg::ADDR_PRI_OVER_E)) begin
                off    = tmx_offset(regAddr, tmx_pkg::ADDR_PRI_OVER);
                pairCh = off[3:1];
                state_d.rdata = off[0] ? state_q.priOver[pairCh][7:0]
                                       : state_q.priOver[pairCh][15:8];
            end else if (tmx_in_range(regAddr, tmx_pkg::ADDR_SEC_OVER,
                                      tmx_pkg::ADDR_SEC_OVER_E)) begin
                off = tmx_offset(regAddr, tmx_pkg::ADDR_SEC_OVER);
                state_d.rdata = state_q.secOver[off[2:0]];
            end else if (tmx_in_range(regAddr, tmx_pkg::ADDR_REF,
                                      tmx_pkg::ADDR_REF_E)) begin
                off    = tmx_offset(regAddr, tmx_pkg::ADDR_REF);
                pairCh = off[3:1];
                state_d.rdata = off[0] ? state_q.refTemp[pairCh][7:0]
                                       : state_q.refTemp[pairCh][15:8];
            end else begin
                unique case (regAddr)
                    tmx_pkg::ADDR_PRI_HIGH: begin
                        state_d.rdata = tmx_status_byte(state_q.priHigh);
                        clrPh         = 5'h1f;
                    end
                    tmx_pkg::ADDR_PRI_LOW: begin
                        state_d.rdata = tmx_status_byte(state_q.priLow);
                        clrPl         = 5'h1f;
                    end
                    tmx_pkg::ADDR_SEC_HIGH: begin
                        state_d.rdata = tmx_status_byte(state_q.secHigh);
                        clrSh         = 5'h1f;
                    end
                    tmx_pkg::ADDR_SEC_LOW: begin
                        state_d.rdata = tmx_status_byte(state_q.secLow);
                        clrSl         = 5'h1f;
                    end
                    tmx_pkg::ADDR_HOT_SEL: begin
                        state_d.rdata = {3'h0, state_q.hotSel};
                    end
                    tmx_pkg::ADDR_UNDER_MSB: begin
                        state_d.rdata = state_q.priUnder[15:8];
                    end
                    tmx_pkg::ADDR_UNDER_LSB: begin
                        state_d.rdata = state_q.priUnder[7:0];
                    end
                    tmx_pkg::ADDR_SEC_UNDER: begin
                        state_d.rdata = state_q.secUnder;
                    end
                    tmx_pkg::ADDR_HOT_MSB: begin
                        state_d.rdata      = state_q.hottest[15:8];
                        // lsb frozen so a conversion between reads cannot tear the pair
                        state_d.hotLsbHold = state_q.hottest[7:0];
                    end
                    tmx_pkg::ADDR_HOT_LSB: begin
                        state_d.rdata = state_q.hotLsbHold;
                    end
                    default: begin
                        state_d.rdata = 8'h00;
                    end
                endcase
            end
        end

        // -------------------------------------------------------------------
        // conversion results
        // -------------------------------------------------------------------
        if (convDone && chOk) begin
            fresh = convTemp - state_q.refTemp[convCh];
            state_d.diff[convCh]      = fresh;
            state_d.diffValid[convCh] = 1'b1;
            if (!convDiodeFault) begin
                if (tmx_gt16(convTemp, state_q.priOver[convCh])) begin
                    setPh = chBit;
                end
                if (tmx_gt16(state_q.priUnder, convTemp)) begin
                    setPl = chBit;
                end
                if (tmx_gt8(convTemp[15:8], state_q.secOver[convCh])) begin
                    setSh = chBit;
                end
                if (tmx_gt8(state_q.secUnder, convTemp[15:8])) begin
                    setSl = chBit;
                end
            end
            state_d.nvLog = nvWriteEnable && ((setPh | setPl) != 5'h00);

            for (int i = 0; i < CH; i++) begin
                if (state_q.hotSel[i] && state_d.diffValid[i]) begin
                    if (!found || tmx_gt16(state_d.diff[i], best)) begin
                        best = state_d.diff[i];
                    end
                    found = 1'b1;
                end
            end
            if (found) begin
                state_d.hottest = best;
            end
        end

        // -------------------------------------------------------------------
        // status and alarms
        // -------------------------------------------------------------------
        // set wins over read clear
        state_d.priHigh = (state_q.priHigh & ~clrPh) | setPh;
        state_d.priLow  = (state_q.priLow  & ~clrPl) | setPl;
        state_d.secHigh = (state_q.secHigh & ~clrSh) | setSh;
        state_d.secLow  = (state_q.secLow  & ~clrSl) | setSl;

        // alarms follow sticky status, so only a read or a set mask bit lets them go
        // faulted channel sets nothing
        state_d.alarm1N = ~|((state_d.priHigh | state_d.priLow) & ~primaryMask);
        state_d.alarm2N = ~|((state_d.secHigh | state_d.secLow) & ~secondaryMask);
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q            <= '0;
            state_q.hotSel     <= tmx_pkg::RST_HOT_SEL;
            state_q.priOver    <= {CH{tmx_pkg::RST_PRI_OVER}};
            state_q.priUnder   <= tmx_pkg::RST_PRI_UNDER;
            state_q.secOver    <= {CH{tmx_pkg::RST_SEC_OVER}};
            state_q.secUnder   <= tmx_pkg::RST_SEC_UNDER;
            state_q.refTemp    <= {CH{tmx_pkg::RST_REF}};
            state_q.alarm1N    <= 1'b1;
            state_q.alarm2N    <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // extended-format bit only changes how the host reads values
    // no device-side offset
    logic unusedExt;
    assign unusedExt = extFormat;

    assign regRdata          = state_q.rdata;
    assign nvLogWrite        = state_q.nvLog;
    assign primary_alarm_n   = state_q.alarm1N;
    assign secondary_alarm_n = state_q.alarm2N;

endmodule : tmx_thermal_logic

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// ----
// bench top
// ----
module testbench;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  regAddr, regWdata, regRdata;
    logic        regWrite, regRead, nvLogWrite, primary_alarm_n, secondary_alarm_n;
    logic        convDone = 1'b0;
    logic [2:0]  convChannel = 3'h0;
    logic [15:0] convTemp = 16'h0000;
    logic        convDiodeFault = 1'b0;
    logic        extFormat = 1'b0;
    logic [4:0]  primaryMask = 5'h00;
    logic [4:0]  secondaryMask = 5'h00;
    logic        nvWriteEnable = 1'b1;
    logic        rdPend = 1'b0;
    logic [15:0] lfsr = 16'hea85;
    logic [15:0] hotExp, oldHot;
    logic [15:0] diff [5];
    logic [15:0] ref16 [5];
    logic [4:0]  seen, sel;
    logic [7:0]  expQ [$];
    int          mismatches = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #5 clock = ~clock;

    tmx_thermal_logic tmx_thermal_logic_inst (.clock, .nrst, .regAddr, .regWrite, .regWdata,
        .regRead, .regRdata, .convDone, .convChannel, .convTemp, .convDiodeFault, .extFormat,
        .primaryMask, .secondaryMask, .nvWriteEnable, .nvLogWrite, .primary_alarm_n,
        .secondary_alarm_n);
    tmx_host_model tmx_host_model_inst (.clock, .regAddr, .regWrite, .regWdata, .regRead);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] got, input logic [15:0] want, input string m);
        total_checks++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask : check

    // read data is due one cycle after the strobe
    always @(negedge clock) begin
        if (rdPend)
            check({8'h00, regRdata}, {8'h00, expQ.pop_front()}, "read");
        rdPend = regRead;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    function automatic void nxt();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    endfunction : nxt

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        tmx_host_model_inst.rd(a);
    endtask : rd

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        seen = 5'h00;
        sel = 5'h1f;
        hotExp = 16'h0000;
        foreach (ref16[i])
            ref16[i] = 16'h0000;
    endtask : do_reset

    task automatic conv(input logic [2:0] ch, input logic [15:0] t, input logic f);
        logic        any;
        logic [15:0] m;
        @(posedge clock);
        convDone <= 1'b1;
        convChannel <= ch;
        convTemp <= t;
        convDiodeFault <= f;
        @(posedge clock);
        convDone <= 1'b0;
        convTemp <= ~t;
        #1;
        diff[ch] = t - ref16[ch];
        seen[ch] = 1'b1;
        any = 1'b0;
        m = 16'h0000;
        for (int i = 0; i < 5; i++)
            if (sel[i] && seen[i] && (!any || $signed(diff[i]) > $signed(m))) begin
                m = diff[i];
                any = 1'b1;
            end
        if (any)
            hotExp = m;
    endtask : conv

    initial begin
        do_reset();
        rd(8'h1a, 8'h1f);
        rd(8'h0c, 8'h00);
        tmx_host_model_inst.wr(8'h45, 8'h5a);
        rd(8'h45, 8'h00);
        rd(8'h00, 8'h00);
        // secondary limits set to the upper byte of the primary ones
        for (int n = 0; n < 5; n++) begin
            tmx_host_model_inst.wr16(8'(8'h1d + 2 * n), 16'h7ff0);
            tmx_host_model_inst.wr(8'(8'h29 + n), 8'h7f);
        end
        tmx_host_model_inst.wr16(8'h27, 16'h8000);
        tmx_host_model_inst.wr(8'h2e, 8'h80);
        tmx_host_model_inst.wr16(8'h21, 16'h1900);
        conv(3'h2, 16'h1900, 1'b0);
        check(primary_alarm_n, 1'b1, "equal not over");
        conv(3'h2, 16'h1910, 1'b0);
        check(primary_alarm_n, 1'b0, "over alarm");
        check(nvLogWrite, 1'b1, "log write");
        @(posedge clock);
        extFormat <= 1'b1;
        rd(8'h0c, 8'h04);
        rd(8'h0c, 8'h00);
        check(primary_alarm_n, 1'b1, "cleared alarm");
        rd(8'h21, 8'h19);
        conv(3'h2, 16'h1910, 1'b0);
        rd(8'h0c, 8'h04);
        @(posedge clock);
        primaryMask <= 5'h04;
        nvWriteEnable <= 1'b0;
        conv(3'h2, 16'h1910, 1'b0);
        check(primary_alarm_n, 1'b1, "masked alarm");
        check(nvLogWrite, 1'b0, "log disabled");
        rd(8'h0c, 8'h04);
        @(posedge clock);
        primaryMask <= 5'h00;
        nvWriteEnable <= 1'b1;
        tmx_host_model_inst.wr(8'h2a, 8'h20);
        conv(3'h1, 16'h20f0, 1'b0);
        check(secondary_alarm_n, 1'b1, "upper byte only");
        conv(3'h1, 16'h2100, 1'b0);
        check(secondary_alarm_n, 1'b0, "secondary alarm");
        check(nvLogWrite, 1'b0, "no log on secondary");
        rd(8'h42, 8'h02);
        @(posedge clock);
        secondaryMask <= 5'h02;
        conv(3'h1, 16'h2100, 1'b0);
        check(secondary_alarm_n, 1'b1, "masked secondary");
        rd(8'h42, 8'h02);
        @(posedge clock);
        secondaryMask <= 5'h00;
        tmx_host_model_inst.wr16(8'h27, 16'he700);
        tmx_host_model_inst.wr(8'h2e, 8'he7);
        conv(3'h0, 16'he6f0, 1'b0);
        check(primary_alarm_n, 1'b0, "under primary");
        check(secondary_alarm_n, 1'b0, "under secondary");
        check(nvLogWrite, 1'b1, "under log");
        rd(8'h0d, 8'h01);
        rd(8'h43, 8'h01);
        conv(3'h3, 16'h8000, 1'b1);
        check(primary_alarm_n, 1'b1, "fault quiet");
        check(nvLogWrite, 1'b0, "fault no log");
        rd(8'h0d, 8'h00);
        $display("limit tests done, checks %0d", total_checks);
        do_reset();
        for (int n = 0; n < 5; n++) begin
            nxt();
            ref16[n] = {lfsr[15:4], 4'h0};
            tmx_host_model_inst.wr16(8'(8'h2f + 2 * n), ref16[n]);
        end
        for (int k = 0; k < 12; k++) begin
            nxt();
            if (k == 6) begin
                sel = lfsr[4:0] | 5'h01;
                tmx_host_model_inst.wr(8'h1a, {3'h0, sel});
                rd(8'h1a, {3'h0, sel});
            end
            conv(3'(lfsr % 16'h0005), {lfsr[11:0], 4'h0}, 1'b0);
            rd(8'h45, hotExp[15:8]);
            rd(8'h46, hotExp[7:0]);
        end
        oldHot = hotExp;
        rd(8'h45, oldHot[15:8]);
        conv(3'h0, 16'h7ff0, 1'b0);
        rd(8'h46, oldHot[7:0]);
        rd(8'h45, hotExp[15:8]);
        repeat (4) @(posedge clock);
        $display("hottest tests done, checks %0d", total_checks);
        report_and_stop();
    end
endmodule : testbench

/* File: tb/tmx_host_model.sv */
`timescale 1ns/1ps
// ----
// host register access
// ----
module tmx_host_model (
    input  wire logic       clock,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWdata,
    output logic            regRead
);
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWdata = 8'h00;
        regRead = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regWdata <= ~d;
        #1;
    endtask : wr
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(8'(a + 8'h01), d[7:0]);
    endtask : wr16
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
    endtask : rd
endmodule : tmx_host_model

/* File: tb/tmx_thermal_properties.sv */
`timescale 1ns/1ps
// ----
// port checks
// ----
module tmx_thermal_properties #(
    parameter int CH = tmx_pkg::NUM_CH
) (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       convDone,
    input wire logic [2:0] convChannel,
    input wire logic       convDiodeFault,
    input wire logic [4:0] primaryMask,
    input wire logic [4:0] secondaryMask,
    input wire logic       nvWriteEnable,
    input wire logic       nvLogWrite,
    input wire logic       primary_alarm_n,
    input wire logic       secondary_alarm_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence statusRead;
        regRead && (regAddr == 8'h0c || regAddr == 8'h0d || regAddr == 8'h42
            || regAddr == 8'h43);
    endsequence
    // mask held so only the conversion could move the alarms
    sequence faultConv;
        convDone && convDiodeFault && primary_alarm_n && secondary_alarm_n
            && $stable(primaryMask) && $stable(secondaryMask);
    endsequence
    chk_status_reserved: assert property (statusRead |=> regRdata[7:5] == 3'h0)
        else $error("status read shows upper bits");
    chk_log_cause: assert property (nvLogWrite |->
        $past(convDone && nvWriteEnable && !convDiodeFault && convChannel < CH))
        else $error("log write without valid conversion");
    chk_log_alarm: assert property (nvLogWrite && primaryMask == 5'h00
        && $past(primaryMask) == 5'h00 |-> !primary_alarm_n)
        else $error("log write without primary alarm");
    chk_pri_assert: assert property ($fell(primary_alarm_n) |->
        $past(convDone && !convDiodeFault) || $past(primaryMask) != $past(primaryMask, 2))
        else $error("primary alarm fell without conversion");
    chk_sec_assert: assert property ($fell(secondary_alarm_n) |->
        $past(convDone && !convDiodeFault) || $past(secondaryMask) != $past(secondaryMask, 2))
        else $error("secondary alarm fell without conversion");
    chk_pri_release: assert property ($rose(primary_alarm_n) |->
        $past(regRead) || $past(primaryMask) != $past(primaryMask, 2))
        else $error("primary alarm released without read");
    chk_diode_quiet: assert property (faultConv |=>
        primary_alarm_n && secondary_alarm_n)
        else $error("alarm on faulted conversion");
    chk_rdata_holds: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without read");
endmodule : tmx_thermal_properties

bind tmx_thermal_logic tmx_thermal_properties #(.CH(CH)) tmx_thermal_properties_inst (
    .clock, .nrst, .regAddr, .regRead, .regRdata, .convDone, .convChannel, .convDiodeFault,
    .primaryMask, .secondaryMask, .nvWriteEnable, .nvLogWrite, .primary_alarm_n,
    .secondary_alarm_n);
